// File: src/pfcd_regs.v
// pin function select and input clock divider control registers
// assumes a classic wishbone master on clk_i and pins from outside
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "pfcd_consts.vh"

module pfcd_regs
#(
    parameter DIV_W = 2
)
(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire general_pin_two_i,
    output reg general_pin_two_o,
    output reg general_pin_two_oe_o,
    output reg general_pin_two_pd_o,
    input wire fast_detect_shared_pin_i,
    output reg fast_detect_shared_pin_o,
    output reg fast_detect_shared_pin_oe_o,
    output reg fast_detect_shared_pin_pd_o,
    input wire general_pin_one_i,
    output reg general_pin_one_o,
    output reg general_pin_one_oe_o,
    output reg general_pin_one_pd_o,
    input wire sysref_i,
    input wire fast_detect_i,
    input wire lmfc_i,
    input wire master_next_trigger_i,
    output reg [1:0] osc_chan_sel_o,
    output reg transfer_o,
    output reg slave_next_trigger_in_o,
    output reg div_clk_o,
    output reg div_half_o,
    output reg [3:0] eff_phase_o
);

    // function decode shared by the shared pin and the dedicated pin
    localparam [2:0] FN_OSC = 3'h0;
    localparam [2:0] FN_XFER = 3'h1;
    localparam [2:0] FN_MASTER = 3'h2;
    localparam [2:0] FN_SLAVE = 3'h3;
    localparam [2:0] FN_OFF = 3'h4;
    localparam [2:0] FN_FD = 3'h5;
    localparam [2:0] FN_LMFC = 3'h6;

    function [2:0] pfcd_sec_fn;
        input [3:0] code;
        input allow_xfer;
        begin
            case (code)
                `PFCD_SEC_OSC_SEL: pfcd_sec_fn = FN_OSC;
                `PFCD_SEC_TRANSFER:
                    pfcd_sec_fn = allow_xfer ? FN_XFER : FN_OFF;
                `PFCD_SEC_MASTER: pfcd_sec_fn = FN_MASTER;
                `PFCD_SEC_SLAVE: pfcd_sec_fn = FN_SLAVE;
                default: pfcd_sec_fn = FN_OFF;
            endcase
        end
    endfunction

    reg [7:0] primary_reg;
    reg [7:0] secondary_reg;
    reg [3:0] first_pin_reg;
    reg [2:0] ratio_reg;
    reg [3:0] phase_reg;
    reg autophase_reg;
    reg [3:0] captured_reg;
    reg ack_reg;
    reg [DIV_W-1:0] div_cnt_reg;
    reg [7:0] div_line_reg;
    reg sysref_last_reg;
    wire [3:0] pin_level;

    wire [9:0] idx = wb_adr_i[11:2];
    wire req = wb_cyc_i & wb_stb_i;
    wire wr_lane0 = ack_reg & wb_we_i & wb_sel_i[0];

    // input synchronisers: pins, then sysref
    wire [3:0] pin_raw = {sysref_i, general_pin_one_i,
                          fast_detect_shared_pin_i, general_pin_two_i};
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : sync
            reg [`PFCD_SYNC_STAGES-1:0] stage_reg;
            reg level_reg;
            always @(posedge clk_i)
            begin
                if (rst_i)
                    stage_reg <= 3'h0;
                else
                    stage_reg <= {stage_reg[1:0], pin_raw[g]};
            end
            // level only moves once the last two stages agree
            always @(posedge clk_i)
            begin
                if (rst_i)
                    level_reg <= 1'b0;
                else if (stage_reg[1] == stage_reg[2])
                    level_reg <= stage_reg[2];
            end
            // one driver per bit keeps the level vector single-sourced
            assign pin_level[g] = level_reg;
        end
    endgenerate

    // bus answer: ack one cycle after the request, dropped the next
    always @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= req & ~ack_reg;
    end
    assign wb_ack_o = ack_reg;

    // read data latched as ack rises, unmapped reads as zero
    always @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0;
        else if (req & ~ack_reg)
        begin
            case (idx)
                `PFCD_IDX_PRIMARY: wb_dat_o <= {24'h0, primary_reg};
                `PFCD_IDX_SECONDARY: wb_dat_o <= {24'h0, secondary_reg};
                `PFCD_IDX_FIRST_PIN:
                    wb_dat_o <= {24'h0, `PFCD_FIRST_PIN_RSVD, first_pin_reg};
                `PFCD_IDX_RATIO: wb_dat_o <= {29'h0, ratio_reg};
                `PFCD_IDX_PHASE: wb_dat_o <= {28'h0, phase_reg};
                `PFCD_IDX_SYSREF_CTRL:
                    wb_dat_o <= {24'h0, autophase_reg, 7'h0};
                `PFCD_IDX_CAPTURED: wb_dat_o <= {28'h0, captured_reg};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    // writes land on the edge where the master sees ack
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            primary_reg <= `PFCD_RST_PRIMARY;
            secondary_reg <= `PFCD_RST_SECONDARY;
            first_pin_reg <= `PFCD_RST_FIRST_PIN;
            ratio_reg <= `PFCD_RST_RATIO;
            phase_reg <= `PFCD_RST_PHASE;
            autophase_reg <= 1'b0;
        end
        else if (wr_lane0)
        begin
            case (idx)
                `PFCD_IDX_PRIMARY: primary_reg <= wb_dat_i[7:0];
                `PFCD_IDX_SECONDARY: secondary_reg <= wb_dat_i[7:0];
                `PFCD_IDX_FIRST_PIN: first_pin_reg <= wb_dat_i[3:0];
                `PFCD_IDX_RATIO: ratio_reg <= wb_dat_i[2:0];
                `PFCD_IDX_PHASE: phase_reg <= wb_dat_i[3:0];
                `PFCD_IDX_SYSREF_CTRL:
                    autophase_reg <= wb_dat_i[`PFCD_AUTOPHASE_BIT];
                default: ;
            endcase
        end
    end

    // divider modulus; unlisted codes fall back to divide by one
    reg [DIV_W-1:0] div_last;
    always @*
    begin
        case (ratio_reg)
            `PFCD_DIV_2: div_last = 2'h1;
            `PFCD_DIV_4: div_last = 2'h3;
            default: div_last = 2'h0;
        endcase
    end

    // divider counter, divided clock high for the first half period
    wire div_raw = (div_last == 2'h0) ? 1'b1 :
                   (div_cnt_reg <= (div_last >> 1));
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_cnt_reg <= 2'h0;
            div_line_reg <= 8'h0;
        end
        else
        begin
            div_cnt_reg <= (div_cnt_reg >= div_last) ? 2'h0 :
                           div_cnt_reg + 2'h1;
            div_line_reg <= {div_line_reg[6:0], div_raw};
        end
    end

    // sysref capture of the divider phase in half-cycle units
    wire sysref_rise = pin_level[3] & ~sysref_last_reg;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sysref_last_reg <= 1'b0;
            captured_reg <= 4'h0;
        end
        else
        begin
            sysref_last_reg <= pin_level[3];
            if (sysref_rise & autophase_reg)
                captured_reg <= {1'b0, div_cnt_reg, 1'b0};
        end
    end

    // effective phase; sum wraps in four bits like the field
    wire [3:0] eff_phase = autophase_reg ?
        captured_reg + phase_reg : phase_reg;

    // whole cycles from the delay line, odd step asks for inversion
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            eff_phase_o <= 4'h0;
            div_clk_o <= 1'b0;
            div_half_o <= 1'b0;
        end
        else
        begin
            eff_phase_o <= eff_phase;
            div_clk_o <= (eff_phase[3:1] == 3'h0) ? div_raw :
                         div_line_reg[eff_phase[3:1] - 3'h1];
            div_half_o <= eff_phase[0];
        end
    end

    // pin function selection from primary, secondary and first pin fields
    reg [2:0] fd_fn;
    reg gp2_osc;
    reg [2:0] gp1_fn;
    always @*
    begin
        gp2_osc = 1'b0;
        if (primary_reg[5:3] == `PFCD_PRI_SECONDARY)
            gp2_osc = (secondary_reg[7:4] == `PFCD_SEC_OSC_SEL);
        case (primary_reg[2:0])
            `PFCD_PRI_FAST_DETECT: fd_fn = FN_FD;
            `PFCD_PRI_LMFC: fd_fn = FN_LMFC;
            `PFCD_PRI_SECONDARY:
                fd_fn = pfcd_sec_fn(secondary_reg[3:0], 1'b1);
            default: fd_fn = FN_OFF;
        endcase
        gp1_fn = pfcd_sec_fn(first_pin_reg, 1'b0);
    end

    // pin drivers and decoded inputs, all registered
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            general_pin_two_o <= 1'b0;
            general_pin_two_oe_o <= 1'b0;
            general_pin_two_pd_o <= 1'b1;
            fast_detect_shared_pin_o <= 1'b0;
            fast_detect_shared_pin_oe_o <= 1'b0;
            fast_detect_shared_pin_pd_o <= 1'b1;
            general_pin_one_o <= 1'b0;
            general_pin_one_oe_o <= 1'b0;
            general_pin_one_pd_o <= 1'b0;
            osc_chan_sel_o <= 2'h0;
            transfer_o <= 1'b0;
            slave_next_trigger_in_o <= 1'b0;
        end
        else
        begin
            // second pin is only ever an input
            general_pin_two_o <= 1'b0;
            general_pin_two_oe_o <= 1'b0;
            general_pin_two_pd_o <= ~gp2_osc;
            osc_chan_sel_o[1] <= gp2_osc & pin_level[0];

            // shared pin drives fast detect, lmfc or master trigger
            fast_detect_shared_pin_oe_o <= (fd_fn == FN_FD) |
                (fd_fn == FN_LMFC) | (fd_fn == FN_MASTER);
            fast_detect_shared_pin_o <=
                (fd_fn == FN_FD) ? fast_detect_i :
                (fd_fn == FN_LMFC) ? lmfc_i :
                (fd_fn == FN_MASTER) & master_next_trigger_i;
            fast_detect_shared_pin_pd_o <= (fd_fn == FN_OFF);

            // dedicated pin; unlisted codes also leave it pulled down
            general_pin_one_oe_o <= (gp1_fn == FN_MASTER);
            general_pin_one_o <= (gp1_fn == FN_MASTER) &
                master_next_trigger_i;
            general_pin_one_pd_o <= (gp1_fn == FN_OFF);

            // oscillator select bit 0 from either pin choosing it
            osc_chan_sel_o[0] <=
                ((fd_fn == FN_OSC) & pin_level[1]) |
                ((gp1_fn == FN_OSC) & pin_level[2]);
            transfer_o <= (fd_fn == FN_XFER) & pin_level[1];
            slave_next_trigger_in_o <=
                ((fd_fn == FN_SLAVE) & pin_level[1]) |
                ((gp1_fn == FN_SLAVE) & pin_level[2]);
        end
    end

endmodule

// File: src/pfcd_consts.vh
// pin function and clock divider register constants
// assumes a 32-bit classic wishbone slave, one word per register index
`ifndef PFCD_CONSTS_VH
`define PFCD_CONSTS_VH

// register indices, byte address is four times the index
`define PFCD_IDX_PRIMARY 10'h040
`define PFCD_IDX_SECONDARY 10'h041
`define PFCD_IDX_FIRST_PIN 10'h042
`define PFCD_IDX_RATIO 10'h108
`define PFCD_IDX_PHASE 10'h109
`define PFCD_IDX_SYSREF_CTRL 10'h10a
`define PFCD_IDX_CAPTURED 10'h129

// reset values
`define PFCD_RST_PRIMARY 8'h3f
`define PFCD_RST_SECONDARY 8'h00
`define PFCD_RST_FIRST_PIN 4'h0
`define PFCD_RST_RATIO 3'h0
`define PFCD_RST_PHASE 4'h0
`define PFCD_FIRST_PIN_RSVD 4'hf

// field positions
`define PFCD_AUTOPHASE_BIT 7

// pin function codes
`define PFCD_PRI_SECONDARY 3'h6
`define PFCD_PRI_FAST_DETECT 3'h0
`define PFCD_PRI_LMFC 3'h1
`define PFCD_SEC_OSC_SEL 4'h0
`define PFCD_SEC_TRANSFER 4'h1
`define PFCD_SEC_MASTER 4'h8
`define PFCD_SEC_SLAVE 4'h9
`define PFCD_SEC_DISABLED 4'hf

// divide ratio codes
`define PFCD_DIV_1 3'h0
`define PFCD_DIV_2 3'h1
`define PFCD_DIV_4 3'h3

// pin input synchroniser depth
`define PFCD_SYNC_STAGES 3

`endif

// File: testbench/pfcd_regs_checker.sv
// assertions on the pin function and clock divider register ports
// assumes one clock clk_i and a synchronous active high rst_i
`timescale 1ns/1ps

module pfcd_regs_checker
(
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic [31:0] wb_dat_o,
    input logic general_pin_two_o,
    input logic general_pin_two_oe_o,
    input logic general_pin_one_o,
    input logic general_pin_one_oe_o,
    input logic general_pin_one_pd_o,
    input logic fast_detect_shared_pin_o,
    input logic fast_detect_shared_pin_oe_o,
    input logic master_next_trigger_i,
    input logic div_half_o,
    input logic [3:0] eff_phase_o
);
    // single domain, so clock and reset are stated once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // bus answer comes one cycle after the take and lasts one cycle
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without request");
    a_dat_narrow: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above byte");
    // second pin has input functions only
    a_two_input: assert property
        (!general_pin_two_oe_o && !general_pin_two_o) else $error("pin two");
    // half step must follow the low bit of the settled phase
    a_half_step: assert property
        ($stable(eff_phase_o) |-> div_half_o == eff_phase_o[0])
        else $error("half step mismatch");
    // a disabled pin must never drive against its pull-down
    a_one_pd_oe: assert property
        (general_pin_one_pd_o |-> !general_pin_one_oe_o)
        else $error("pin one drives while disabled");
    a_one_master: assert property
        (general_pin_one_oe_o && $past(general_pin_one_oe_o)
        |-> general_pin_one_o == $past(master_next_trigger_i))
        else $error("pin one not following trigger");
    // an undriven shared pin must keep its data line low
    a_shared_quiet: assert property
        (!fast_detect_shared_pin_oe_o |-> !fast_detect_shared_pin_o)
        else $error("shared pin data without enable");

    cover property (wb_ack_o && wb_cyc_i);
    cover property (fast_detect_shared_pin_oe_o && fast_detect_shared_pin_o);
    cover property (general_pin_one_oe_o);
    cover property (div_half_o);
endmodule

bind pfcd_regs pfcd_regs_checker u_pfcd_chk (.*);

// File: testbench/test_pfcd_regs.sv
// random and corner tests of the pin function and divider registers
// assumes pfcd_regs with its checker bound, 50 MHz clock, sync reset
`timescale 1ns/1ps

module test_pfcd_regs;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [11:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic general_pin_two_i = 0, fast_detect_shared_pin_i = 0;
    logic general_pin_one_i = 0, sysref_i = 0, fast_detect_i = 0;
    logic lmfc_i = 0, master_next_trigger_i = 0, wb_ack_o;
    logic general_pin_two_o, general_pin_two_oe_o, general_pin_two_pd_o;
    logic fast_detect_shared_pin_o, fast_detect_shared_pin_oe_o;
    logic fast_detect_shared_pin_pd_o, general_pin_one_o, transfer_o;
    logic general_pin_one_oe_o, general_pin_one_pd_o, div_clk_o;
    logic slave_next_trigger_in_o, div_half_o;
    logic [1:0] osc_chan_sel_o;
    logic [3:0] eff_phase_o;
    logic [7:0] q, cap, off, p, s, d;
    logic [2:0] pc[4] = '{3'h0, 3'h1, 3'h6, 3'h7};
    logic [3:0] sc[5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hf};
    int bad_count = 0, n_tests = 0, k;

    pfcd_regs #(.DIV_W(2)) DUT (.*);

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    // core-side sources toggle freely so driven pins carry traffic
    always @(posedge clk_i)
        {fast_detect_i, lmfc_i, master_next_trigger_i} <= 3'($urandom);

    task automatic test_done;
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; bounded wait so a dead slave ends the run
    task automatic wb(input logic w, input logic [9:0] ix,
        input logic [7:0] v);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {ix, 2'b00};
        wb_dat_i <= {24'h0, v};
        for (n = 0; n < 16 && wb_ack_o !== 1'b1; n++)
            @(posedge clk_i);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
        if (n == 16)
        begin
            bad_count++;
            test_done;
        end
    endtask

    task automatic rd(input logic [9:0] ix, input logic [7:0] exp);
        wb(1'b0, ix, 8'h00);
        chk(q, exp);
    endtask

    task automatic sysref_pulse;
        sysref_i <= 1'b1;
        wt(6);
        sysref_i <= 1'b0;
        wt(6);
    endtask

    // counts rising edges of the divided clock over sixteen cycles
    task automatic edges(input logic [7:0] exp);
        int c;
        logic pv;
        c = 0;
        // let the phase delay line flush the old ratio first
        wt(10);
        pv = div_clk_o;
        repeat (16)
        begin
            @(posedge clk_i);
            c += (div_clk_o === 1'b1 && pv === 1'b0);
            pv = div_clk_o;
        end
        chk(c[7:0], exp);
    endtask

    // packs {osc sel, transfer, slave, pd two, pd one, oe one, oe shared}
    function automatic logic [7:0] pin_exp(input logic [7:0] p, s, d,
        input logic a, b, c);
        logic t, h;
        t = p[5:3] == 3'h6 && s[7:4] == 4'h0;
        h = p[2:0] == 3'h6;
        pin_exp[7] = t & a;
        pin_exp[6] = (h && s[3:0] == 4'h0 && b) || (d[3:0] == 4'h0 && c);
        pin_exp[5] = h && s[3:0] == 4'h1 && b;
        pin_exp[4] = (h && s[3:0] == 4'h9 && b) || (d[3:0] == 4'h9 && c);
        pin_exp[3] = !t;
        pin_exp[2] = !(d[3:0] == 4'h0 || d[3:0] == 4'h8 || d[3:0] == 4'h9);
        pin_exp[1] = d[3:0] == 4'h8;
        pin_exp[0] = p[2:1] == 2'b00 || (h && s[3:0] == 4'h8);
    endfunction

    initial
    begin
        void'($urandom(32'h33f77cc0));
        wt(2);
        rst_i <= 1'b0;
        wt(4);
        rd(10'h040, 8'h3f);
        rd(10'h041, 8'h00);
        rd(10'h042, 8'hf0);
        rd(10'h108, 8'h00);
        wb(1'b1, 10'h109, 8'hff);
        rd(10'h109, 8'h0f);
        wb(1'b1, 10'h3ff, 8'hff);
        rd(10'h3ff, 8'h00);
        // a write with lane zero disabled must be ignored
        wb_sel_i <= 4'h0;
        wb(1'b1, 10'h108, 8'h03);
        wb_sel_i <= 4'h1;
        rd(10'h108, 8'h00);
        wb(1'b1, 10'h108, 8'h01);
        edges(8'h08);
        wb(1'b1, 10'h108, 8'h03);
        edges(8'h04);
        // offsets with sysref pulses while autophase is off
        for (k = 0; k < 6; k++)
        begin
            off = (k == 0) ? 8'h01 : {4'h0, 4'($urandom)};
            wb(1'b1, 10'h109, off);
            sysref_pulse;
            chk({4'h0, eff_phase_o}, off);
            chk({7'h0, div_half_o}, {7'h0, off[0]});
        end
        wb(1'b1, 10'h10a, 8'h80);
        sysref_pulse;
        wb(1'b0, 10'h129, 8'h00);
        cap = q;
        chk(cap & 8'hf9, 8'h00);
        chk({4'h0, eff_phase_o}, (cap + off) & 8'h0f);
        wb(1'b1, 10'h10a, 8'h00);
        sysref_pulse;
        rd(10'h129, cap);
        chk({4'h0, eff_phase_o}, off);
        // random pin configurations and pin levels
        for (k = 0; k < 40; k++)
        begin
            p = {2'b00, pc[$urandom % 2 + 2], pc[$urandom % 4]};
            s = {sc[$urandom % 5], sc[$urandom % 5]};
            d = {4'h0, sc[$urandom % 5]};
            wb(1'b1, 10'h040, p);
            wb(1'b1, 10'h041, s);
            wb(1'b1, 10'h042, d);
            {general_pin_two_i, fast_detect_shared_pin_i} <= 2'($urandom);
            general_pin_one_i <= 1'($urandom);
            wt(8);
            chk({osc_chan_sel_o, transfer_o, slave_next_trigger_in_o,
                general_pin_two_pd_o, general_pin_one_pd_o,
                general_pin_one_oe_o, fast_detect_shared_pin_oe_o},
                pin_exp(p, s, d, general_pin_two_i, fast_detect_shared_pin_i,
            general_pin_one_i));
            chk({7'h0, fast_detect_shared_pin_pd_o}, {7'h0, p[2:0] == 3'h7 ||
                (p[2:0] == 3'h6 && s[3:0] == 4'hf)});
        end
        test_done;
    end
endmodule
